/* rtl/micro_move_incdec_pkg.sv */
// Purpose: shared constants for the move / increment / decrement datapath slice
// Assumes: 16-bit microinstruction words, sixteen 8-bit scratch registers
// Notes: opcode groups are microinstruction bits 15..9, bit 8 picks the flag-updating form, or decrement in the conditional inc/dec group
package micro_move_incdec_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int REG_COUNT = 16;
  localparam int IDX_W = 4;
  localparam int MI_W = 16;
  localparam int OP_W = 7;
  localparam int BUS_ADDR_W = 5;

  // microinstruction field positions
  localparam int OP_HI = 15;
  localparam int OP_LO = 9;
  localparam int FLAG_SEL_BIT = 8;
  localparam int B_HI = 7;
  localparam int B_LO = 4;
  localparam int A_HI = 3;
  localparam int A_LO = 0;

  // opcode groups, bits 15..9
  localparam logic [OP_W-1:0] OP_MOVE_WORD = 7'h41;
  localparam logic [OP_W-1:0] OP_COND_MOVE_WORD = 7'h43;
  localparam logic [OP_W-1:0] OP_INC_BYTE_ONE = 7'h48;
  localparam logic [OP_W-1:0] OP_INC_WORD_ONE = 7'h49;
  localparam logic [OP_W-1:0] OP_INC_BYTE_TWO = 7'h4a;
  localparam logic [OP_W-1:0] OP_DEC_BYTE_ONE = 7'h5e;
  localparam logic [OP_W-1:0] OP_COND_INCDEC_BYTE = 7'h3b;

  // flag byte layout
  localparam int F_NB = 7;
  localparam int F_ZB = 6;
  localparam int F_HC = 5;
  localparam int F_FC = 4;
  localparam int F_N = 3;
  localparam int F_Z = 2;
  localparam int F_V = 1;
  localparam int F_C = 0;

  localparam logic [BYTE_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] SCRATCH_RESET = 8'h00;

  // register port map: scratch registers at 0x00-0x0f, flag byte at 0x10
  localparam logic [BUS_ADDR_W-1:0] ADDR_FLAGS = 5'h10;
  localparam int ADDR_BANK_BIT = 4;

  // addends
  localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [BYTE_W-1:0] BYTE_TWO = 8'h02;
  localparam logic [BYTE_W-1:0] BYTE_MINUS_ONE = 8'hff;
  localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;

  typedef enum logic [3:0] {
    OPK_NONE,
    OPK_MOVE_WORD,
    OPK_COND_MOVE_WORD,
    OPK_INC_BYTE_ONE,
    OPK_INC_BYTE_TWO,
    OPK_DEC_BYTE_ONE,
    OPK_COND_INC,
    OPK_COND_DEC,
    OPK_INC_WORD
  } op_kind_t;
endpackage

/* rtl/incdec_adder.sv */
// Purpose: adder with carry out, bit 3 carry and signed overflow
// Assumes: W of at least 5 bits
// Notes: decrement is done by adding all ones, so carry out means no borrow
`timescale 1ns/1ns
`default_nettype none
module incdec_adder #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  output logic [W-1:0] o_sum,
  output logic o_carry,
  output logic o_half_carry,
  output logic o_overflow
);
  logic [W:0] full;
  logic [4:0] low;

  if (W < 5) begin : g_bad_width
    $error("incdec_adder needs at least 5 bits");
  end

  // full sum and nibble sum side by side so bit 3 carry needs no tap
  always_comb begin
    full = {1'b0, i_a} + {1'b0, i_b};
    low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    o_sum = full[W-1:0];
    o_carry = full[W];
    o_half_carry = low[4];
    o_overflow = (i_a[W-1] == i_b[W-1]) && (full[W-1] != i_a[W-1]);
  end
endmodule
`default_nettype wire

/* rtl/scratch_regfile.sv */
// Purpose: scratch register bank, four read ports and two write ports
// Assumes: the high write port is the second byte of a register pair
// Notes: if both write ports hit one entry, the high port wins
`timescale 1ns/1ns
`default_nettype none
module scratch_regfile #(
  parameter int COUNT = 16,
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [AW-1:0] i_raddr_0,
  input wire logic [AW-1:0] i_raddr_1,
  input wire logic [AW-1:0] i_raddr_2,
  input wire logic [AW-1:0] i_raddr_3,
  output logic [W-1:0] o_rdata_0,
  output logic [W-1:0] o_rdata_1,
  output logic [W-1:0] o_rdata_2,
  output logic [W-1:0] o_rdata_3,
  input wire logic i_we_lo,
  input wire logic [AW-1:0] i_waddr_lo,
  input wire logic [W-1:0] i_wdata_lo,
  input wire logic i_we_hi,
  input wire logic [AW-1:0] i_waddr_hi,
  input wire logic [W-1:0] i_wdata_hi
);
  logic [W-1:0] mem_q [COUNT];
  logic [W-1:0] mem_d [COUNT];

  if (COUNT != (1 << AW)) begin : g_bad_count
    $error("scratch_regfile COUNT must be 2**AW");
  end

  // asynchronous reads feed the one-cycle datapath
  assign o_rdata_0 = mem_q[i_raddr_0];
  assign o_rdata_1 = mem_q[i_raddr_1];
  assign o_rdata_2 = mem_q[i_raddr_2];
  assign o_rdata_3 = mem_q[i_raddr_3];

  // next contents
  always_comb begin
    mem_d = mem_q;
    if (i_we_lo) begin
      mem_d[i_waddr_lo] = i_wdata_lo;
    end
    if (i_we_hi) begin
      mem_d[i_waddr_hi] = i_wdata_hi;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      for (int i = 0; i < COUNT; i++) begin
        mem_q[i] <= micro_move_incdec_pkg::SCRATCH_RESET;
      end
    end else begin
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/micro_move_incdec_datapath.sv */
// Purpose: move word, byte/word increment and byte decrement slice of a microcoded datapath
// Assumes: the sequencer offers one decoded word per cycle; every operation takes one cycle
// Notes: opcodes outside this slice are ignored; register port reaches scratch and flags
//
// Summary of operation
// - move word with even source index copies the source pair to the destination pair
// - odd source index moves one byte and fills the high byte with its sign
// - move word sets byte N/Z from the word; flagged form sets N,Z, clears V
// - conditional move word acts only when C is 1, else nothing changes
// - increment byte by one writes source plus one to destination
// - increment byte by two writes source plus two in one cycle
// - byte inc/dec sets half carry from bit 3 and full carry from bit 7
// - flagged byte increment sets N, Z, V and C from the result
// - conditional increment adds one to A only when full carry is 1
// - conditional inc/dec sets byte zero only if it was set and result is zero
// - conditional decrement subtracts one from A only when full carry is 0
// - conditional decrement sets full carry when there is no carry out
// - decrement byte writes source minus one; flagged form sets C on borrow
// - increment and decrement reach scratch registers only, never the indirect pointer
// - increment word adds one to the pair, or to the sign-extended odd byte
// - flag byte holds NB,ZB,HC,FC in bits 7-4 and N,Z,V,C in bits 3-0
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module micro_move_incdec_datapath #(
  parameter int REG_COUNT = 16
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_mi_valid,
  input wire logic [15:0] i_mi_word,
  output logic o_mi_ready,
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [7:0] o_reg_rdata,
  output logic [7:0] o_flags
);
  localparam int BW = micro_move_incdec_pkg::BYTE_W;
  localparam int WW = micro_move_incdec_pkg::WORD_W;
  localparam int IW = micro_move_incdec_pkg::IDX_W;

  if (REG_COUNT != micro_move_incdec_pkg::REG_COUNT) begin : g_bad_regs
    $error("index fields address exactly sixteen scratch registers");
  end

  micro_move_incdec_pkg::op_kind_t op_kind;
  logic flagged, bcarry, bhalf, bovf, wcarry, whalf, wovf, we_lo, we_hi, bus_scratch;
  logic [IW-1:0] a_idx, b_idx, a_next_idx, b_next_idx, waddr_lo;
  logic [BW-1:0] rd_a, rd_b, rd_b1, rd_bus, badd_a, badd_b, bsum, wdata_lo, wdata_hi;
  logic [BW-1:0] flags_q, flags_d, rdata_q, rdata_d;
  logic [WW-1:0] src_word, wsum;

  // one operation per cycle, so the sequencer is never held off
  assign o_mi_ready = 1'b1;
  assign o_flags = flags_q;
  assign o_reg_rdata = rdata_q;

  // decode: op group in bits 15..9, bit 8 is the flag-update select except in the conditional inc/dec group
  always_comb begin
    op_kind = micro_move_incdec_pkg::OPK_NONE;
    flagged = i_mi_word[micro_move_incdec_pkg::FLAG_SEL_BIT];
    b_idx = i_mi_word[micro_move_incdec_pkg::B_HI:micro_move_incdec_pkg::B_LO];
    a_idx = i_mi_word[micro_move_incdec_pkg::A_HI:micro_move_incdec_pkg::A_LO];
    if (i_mi_valid) begin
      unique case (i_mi_word[micro_move_incdec_pkg::OP_HI:micro_move_incdec_pkg::OP_LO])
        micro_move_incdec_pkg::OP_MOVE_WORD: op_kind = micro_move_incdec_pkg::OPK_MOVE_WORD;
        micro_move_incdec_pkg::OP_COND_MOVE_WORD: begin
          op_kind = micro_move_incdec_pkg::OPK_COND_MOVE_WORD;
        end
        micro_move_incdec_pkg::OP_INC_BYTE_ONE: op_kind = micro_move_incdec_pkg::OPK_INC_BYTE_ONE;
        micro_move_incdec_pkg::OP_INC_BYTE_TWO: op_kind = micro_move_incdec_pkg::OPK_INC_BYTE_TWO;
        micro_move_incdec_pkg::OP_DEC_BYTE_ONE: op_kind = micro_move_incdec_pkg::OPK_DEC_BYTE_ONE;
        micro_move_incdec_pkg::OP_INC_WORD_ONE: op_kind = micro_move_incdec_pkg::OPK_INC_WORD;
        // bit 8 here picks increment or decrement, not flag update
        micro_move_incdec_pkg::OP_COND_INCDEC_BYTE: begin
          op_kind = flagged ? micro_move_incdec_pkg::OPK_COND_DEC
                            : micro_move_incdec_pkg::OPK_COND_INC;
        end
        default: op_kind = micro_move_incdec_pkg::OPK_NONE;
      endcase
    end
  end

  // pair partners wrap within the bank
  assign a_next_idx = IW'(a_idx + 1'b1);
  assign b_next_idx = IW'(b_idx + 1'b1);
  assign bus_scratch = !i_reg_addr[micro_move_incdec_pkg::ADDR_BANK_BIT];

  // only scratch registers are wired to the adders; no pointer register path exists
  scratch_regfile #(
    .COUNT(micro_move_incdec_pkg::REG_COUNT),
    .W(BW),
    .AW(IW)
  ) u_regs (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_raddr_0(a_idx),
    .i_raddr_1(b_idx),
    .i_raddr_2(b_next_idx),
    .i_raddr_3(i_reg_addr[IW-1:0]),
    .o_rdata_0(rd_a),
    .o_rdata_1(rd_b),
    .o_rdata_2(rd_b1),
    .o_rdata_3(rd_bus),
    .i_we_lo(we_lo),
    .i_waddr_lo(waddr_lo),
    .i_wdata_lo(wdata_lo),
    .i_we_hi(we_hi),
    .i_waddr_hi(a_next_idx),
    .i_wdata_hi(wdata_hi)
  );

  // odd source index means one byte, sign extended into the high byte
  assign src_word = b_idx[0] ? {{BW{rd_b[BW-1]}}, rd_b} : {rd_b1, rd_b};

  // byte adder: conditional forms work on A in place, the rest read B
  always_comb begin
    unique case (op_kind)
      micro_move_incdec_pkg::OPK_COND_INC: begin
        badd_a = rd_a;
        badd_b = micro_move_incdec_pkg::BYTE_ONE;
      end
      micro_move_incdec_pkg::OPK_COND_DEC: begin
        badd_a = rd_a;
        badd_b = micro_move_incdec_pkg::BYTE_MINUS_ONE;
      end
      micro_move_incdec_pkg::OPK_INC_BYTE_TWO: begin
        badd_a = rd_b;
        badd_b = micro_move_incdec_pkg::BYTE_TWO;
      end
      micro_move_incdec_pkg::OPK_DEC_BYTE_ONE: begin
        badd_a = rd_b;
        badd_b = micro_move_incdec_pkg::BYTE_MINUS_ONE;
      end
      default: begin
        badd_a = rd_b;
        badd_b = micro_move_incdec_pkg::BYTE_ONE;
      end
    endcase
  end

  incdec_adder #(
    .W(BW)
  ) u_byte_add (
    .i_a(badd_a),
    .i_b(badd_b),
    .o_sum(bsum),
    .o_carry(bcarry),
    .o_half_carry(bhalf),
    .o_overflow(bovf)
  );

  incdec_adder #(
    .W(WW)
  ) u_word_add (
    .i_a(src_word),
    .i_b(micro_move_incdec_pkg::WORD_ONE),
    .o_sum(wsum),
    .o_carry(wcarry),
    .o_half_carry(whalf),
    .o_overflow(wovf)
  );

  // execute: register writes and next flag byte
  always_comb begin
    flags_d = flags_q;
    we_lo = 1'b0;
    we_hi = 1'b0;
    waddr_lo = a_idx;
    wdata_lo = bsum;
    wdata_hi = wsum[WW-1:BW];
    unique case (op_kind)
      micro_move_incdec_pkg::OPK_MOVE_WORD, micro_move_incdec_pkg::OPK_COND_MOVE_WORD: begin
        // a false condition leaves registers and every flag alone
        if (op_kind == micro_move_incdec_pkg::OPK_MOVE_WORD
            || flags_q[micro_move_incdec_pkg::F_C]) begin
          we_lo = 1'b1;
          we_hi = 1'b1;
          wdata_lo = src_word[BW-1:0];
          wdata_hi = src_word[WW-1:BW];
          flags_d[micro_move_incdec_pkg::F_NB] = src_word[WW-1];
          flags_d[micro_move_incdec_pkg::F_ZB] = (src_word == '0);
          if (flagged) begin
            flags_d[micro_move_incdec_pkg::F_N] = src_word[WW-1];
            flags_d[micro_move_incdec_pkg::F_Z] = (src_word == '0);
            flags_d[micro_move_incdec_pkg::F_V] = 1'b0;
          end
        end
      end
      micro_move_incdec_pkg::OPK_INC_BYTE_ONE, micro_move_incdec_pkg::OPK_INC_BYTE_TWO,
      micro_move_incdec_pkg::OPK_DEC_BYTE_ONE: begin
        we_lo = 1'b1;
        flags_d[micro_move_incdec_pkg::F_NB] = bsum[BW-1];
        flags_d[micro_move_incdec_pkg::F_ZB] = (bsum == '0);
        flags_d[micro_move_incdec_pkg::F_HC] = bhalf;
        flags_d[micro_move_incdec_pkg::F_FC] = bcarry;
        if (flagged) begin
          flags_d[micro_move_incdec_pkg::F_N] = bsum[BW-1];
          flags_d[micro_move_incdec_pkg::F_Z] = (bsum == '0);
          flags_d[micro_move_incdec_pkg::F_V] = bovf;
          // adding all ones: a borrow is the absence of carry
          flags_d[micro_move_incdec_pkg::F_C] =
            (op_kind == micro_move_incdec_pkg::OPK_DEC_BYTE_ONE) ? !bcarry : bcarry;
        end
      end
      micro_move_incdec_pkg::OPK_COND_INC, micro_move_incdec_pkg::OPK_COND_DEC: begin
        if (flags_q[micro_move_incdec_pkg::F_FC]
            == (op_kind == micro_move_incdec_pkg::OPK_COND_INC)) begin
          we_lo = 1'b1;
          flags_d[micro_move_incdec_pkg::F_NB] = bsum[BW-1];
          // chained zero test across a multi-byte count
          flags_d[micro_move_incdec_pkg::F_ZB] =
            flags_q[micro_move_incdec_pkg::F_ZB] && (bsum == '0);
          flags_d[micro_move_incdec_pkg::F_HC] = bhalf;
          flags_d[micro_move_incdec_pkg::F_FC] =
            (op_kind == micro_move_incdec_pkg::OPK_COND_DEC) ? !bcarry : bcarry;
        end
      end
      micro_move_incdec_pkg::OPK_INC_WORD: begin
        we_lo = 1'b1;
        we_hi = 1'b1;
        wdata_lo = wsum[BW-1:0];
        flags_d[micro_move_incdec_pkg::F_NB] = wsum[WW-1];
        flags_d[micro_move_incdec_pkg::F_ZB] = (wsum == '0);
        flags_d[micro_move_incdec_pkg::F_HC] = whalf;
        flags_d[micro_move_incdec_pkg::F_FC] = wcarry;
        if (flagged) begin
          flags_d[micro_move_incdec_pkg::F_N] = wsum[WW-1];
          flags_d[micro_move_incdec_pkg::F_Z] = (wsum == '0);
          flags_d[micro_move_incdec_pkg::F_V] = wovf;
          flags_d[micro_move_incdec_pkg::F_C] = wcarry;
        end
      end
      default: begin
        // port writes only when no operation runs, so microcode always wins
        if (i_reg_write && bus_scratch) begin
          we_lo = 1'b1;
          waddr_lo = i_reg_addr[IW-1:0];
          wdata_lo = i_reg_wdata;
        end
        if (i_reg_write && i_reg_addr == micro_move_incdec_pkg::ADDR_FLAGS) begin
          flags_d = i_reg_wdata;
        end
      end
    endcase
  end

  // read data for the port, valid the cycle after the strobe only
  always_comb begin
    rdata_d = '0;
    if (i_reg_read && bus_scratch) begin
      rdata_d = rd_bus;
    end else if (i_reg_read && i_reg_addr == micro_move_incdec_pkg::ADDR_FLAGS) begin
      rdata_d = flags_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      flags_q <= micro_move_incdec_pkg::FLAGS_RESET;
      rdata_q <= '0;
    end else begin
      flags_q <= flags_d;
      rdata_q <= rdata_d;
    end
  end

  // checks
  property p_mw_even;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_MOVE_WORD && !b_idx[0])
      |-> we_lo && we_hi && wdata_lo == rd_b && wdata_hi == rd_b1;
  endproperty
  a_mw_even: assert property (p_mw_even) else $error("even move word pair mismatch");
  property p_mw_odd;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_MOVE_WORD && b_idx[0])
      |-> wdata_lo == rd_b && wdata_hi == {BW{rd_b[BW-1]}};
  endproperty
  a_mw_odd: assert property (p_mw_odd) else $error("odd move word not sign extended");
  property p_mw_carry_kept;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_MOVE_WORD)
      |=> o_flags[5:4] == $past(o_flags[5:4]) && o_flags[0] == $past(o_flags[0]);
  endproperty
  a_mw_carry_kept: assert property (p_mw_carry_kept) else $error("move word hit carry");
  property p_cmw_skip;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_COND_MOVE_WORD && !o_flags[0])
      |-> !we_lo && !we_hi ##1 $stable(o_flags);
  endproperty
  a_cmw_skip: assert property (p_cmw_skip) else $error("cond move acted with C clear");
  property p_inc_two;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_INC_BYTE_TWO)
      |-> we_lo && wdata_lo == BW'(rd_b + micro_move_incdec_pkg::BYTE_TWO);
  endproperty
  a_inc_two: assert property (p_inc_two) else $error("increment by two wrong");
  property p_cib_zero_chain;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_COND_INC && !o_flags[6]) |=> !o_flags[6];
  endproperty
  a_cib_zero_chain: assert property (p_cib_zero_chain) else $error("zero chain broken");
  property p_cdb_skip;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_COND_DEC && o_flags[4])
      |-> !we_lo ##1 $stable(o_flags);
  endproperty
  a_cdb_skip: assert property (p_cdb_skip) else $error("cond decrement acted");
  property p_cdb_from_zero;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_COND_DEC && !o_flags[4] && rd_a == '0)
      |=> o_flags[4] && o_flags[7];
  endproperty
  a_cdb_from_zero: assert property (p_cdb_from_zero) else $error("no-carry flag wrong");
  property p_dec_byte_one_flagged_op_borrow;
    @(posedge i_clock) disable iff (i_srst)
    (op_kind == micro_move_incdec_pkg::OPK_DEC_BYTE_ONE && flagged && rd_b == '0)
      |=> o_flags[0] && !o_flags[4];
  endproperty
  a_dec_byte_one_flagged_op_borrow: assert property (p_dec_byte_one_flagged_op_borrow) else $error("borrow not flagged");

  c_move_word: cover property (@(posedge i_clock) op_kind == micro_move_incdec_pkg::OPK_MOVE_WORD);
  c_cond_inc: cover property (@(posedge i_clock)
    op_kind == micro_move_incdec_pkg::OPK_COND_INC && o_flags[4]);
  c_cond_dec: cover property (@(posedge i_clock)
    op_kind == micro_move_incdec_pkg::OPK_COND_DEC && !o_flags[4]);
endmodule
`default_nettype wire

/* tb/mi_sequencer_model.sv */
// Purpose: stand-in for the microinstruction sequencer feeding the datapath
// Assumes: ready is always high, so a word is taken at every edge it is offered
// Notes: once valid drops, the word bus holds the inverse of the last word until the next issue
`timescale 1ns/1ns
`default_nettype none
module mi_sequencer_model (
  input wire logic i_clock,
  output logic o_mi_valid,
  output logic [15:0] o_mi_word
);
  initial begin
    o_mi_valid = 1'b0;
    o_mi_word = 16'h0000;
  end

  // one word, or two words back to back, changed just after rising edges
  task automatic issue(input logic [15:0] w1, input logic [15:0] w2, input bit two);
    @(posedge i_clock);
    o_mi_valid <= 1'b1;
    o_mi_word <= w1;
    if (two) begin
      @(posedge i_clock);
      o_mi_word <= w2;
    end
    @(posedge i_clock);
    o_mi_valid <= 1'b0;
    o_mi_word <= ~o_mi_word; // stale word must not look like a held one
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the move / inc / dec datapath slice
// Assumes: results visible one edge after the word is taken, port read data one cycle later
// Notes: flags are preset through the port so each case starts from a known flag byte
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_write = 1'b0;
  logic i_reg_read = 1'b0;
  logic [4:0] i_reg_addr = 5'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_mi_valid;
  logic [15:0] i_mi_word;
  logic o_mi_ready;
  logic [7:0] o_reg_rdata;
  logic [7:0] o_flags;
  int err_total = 0;
  int total_checks = 0;
  localparam logic [4:0] FA = micro_move_incdec_pkg::ADDR_FLAGS;

  always #50 i_clock = ~i_clock;

  mi_sequencer_model u_mi_sequencer_model (.i_clock(i_clock), .o_mi_valid(i_mi_valid),
    .o_mi_word(i_mi_word));
  micro_move_incdec_datapath u_micro_move_incdec_datapath (.i_clock(i_clock), .i_srst(i_srst),
    .i_mi_valid(i_mi_valid), .i_mi_word(i_mi_word), .o_mi_ready(o_mi_ready),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
    .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_flags(o_flags));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [15:0] mk(input logic [6:0] op, input bit f, input int b, input int a);
    return {op, f, b[3:0], a[3:0]};
  endfunction

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_write <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_reg_read <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    #1;
    chk(o_reg_rdata, exp, "read data");
  endtask

  task automatic op(input logic [15:0] w1, input logic [15:0] w2 = 16'h0000, input bit two = 0);
    u_mi_sequencer_model.issue(w1, w2, two);
    #1;
  endtask

  task automatic t_reset();
    chk(o_flags, micro_move_incdec_pkg::FLAGS_RESET, "reset flags");
    chk({7'h00, o_mi_ready}, 8'h01, "ready");
    rd(5'h07, micro_move_incdec_pkg::SCRATCH_RESET);
    wr(5'h1f, 8'h5a);
    rd(5'h1f, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_move();
    wr(5'h02, 8'h34);
    wr(5'h03, 8'h80);
    wr(FA, 8'h03);
    op(mk(micro_move_incdec_pkg::OP_MOVE_WORD, 1, 2, 4));
    chk(o_flags, 8'h89, "move word flagged flags");
    rd(FA, 8'h89);
    rd(5'h04, 8'h34);
    rd(5'h05, 8'h80);
    rd(5'h02, 8'h34);
    wr(FA, 8'h40);
    op(mk(micro_move_incdec_pkg::OP_MOVE_WORD, 0, 3, 6));
    chk(o_flags, 8'h80, "move word plain flags");
    rd(5'h06, 8'h80);
    rd(5'h07, 8'hff);
    $display("test move done");
  endtask

  task automatic t_cond_move();
    wr(5'h08, 8'h11);
    wr(FA, 8'hfe);
    // a flag write in the same cycle as a recognised op must be dropped
    fork
      op(mk(micro_move_incdec_pkg::OP_COND_MOVE_WORD, 1, 2, 8));
      wr(FA, 8'h00);
    join
    chk(o_flags, 8'hfe, "false cond move flags");
    rd(5'h08, 8'h11);
    wr(FA, 8'h01);
    op(mk(micro_move_incdec_pkg::OP_COND_MOVE_WORD, 1, 2, 8));
    chk(o_flags, 8'h89, "cond move flags");
    rd(5'h08, 8'h34);
    rd(5'h09, 8'h80);
    $display("test cond move done");
  endtask

  task automatic t_incdec_byte();
    wr(5'h09, 8'h7f);
    wr(FA, 8'h00);
    op(mk(micro_move_incdec_pkg::OP_INC_BYTE_ONE, 1, 9, 10));
    chk(o_flags, 8'haa, "inc one flagged flags");
    rd(5'h0a, 8'h80);
    rd(5'h09, 8'h7f);
    wr(5'h09, 8'hfe);
    wr(FA, 8'h0f);
    op(mk(micro_move_incdec_pkg::OP_INC_BYTE_TWO, 0, 9, 10));
    chk(o_flags, 8'h7f, "inc two flags");
    rd(5'h0a, 8'h00);
    wr(5'h09, 8'h00);
    wr(FA, 8'h00);
    op(mk(micro_move_incdec_pkg::OP_DEC_BYTE_ONE, 1, 9, 10));
    chk(o_flags, 8'h89, "dec flagged flags");
    rd(5'h0a, 8'hff);
    $display("test inc dec byte done");
  endtask

  task automatic t_cond_incdec();
    logic [15:0] ci;
    logic [15:0] cd;
    ci = mk(micro_move_incdec_pkg::OP_COND_INCDEC_BYTE, 0, 5, 11);
    cd = mk(micro_move_incdec_pkg::OP_COND_INCDEC_BYTE, 1, 5, 11);
    wr(5'h0b, 8'hff);
    wr(FA, 8'h5f);
    op(ci, ci, 1);
    chk(o_flags, 8'h0f, "back to back cond inc");
    op(ci);
    chk(o_flags, 8'h0f, "cond inc skipped");
    rd(5'h0b, 8'h01);
    op(cd);
    chk(o_flags, 8'h2f, "cond dec to zero");
    op(cd);
    chk(o_flags, 8'h9f, "cond dec wraps");
    op(cd);
    chk(o_flags, 8'h9f, "cond dec skipped");
    rd(5'h0b, 8'hff);
    $display("test cond inc dec done");
  endtask

  task automatic t_inc_word();
    wr(5'h0c, 8'hff);
    wr(5'h0d, 8'h7f);
    wr(FA, 8'h00);
    op(mk(micro_move_incdec_pkg::OP_INC_WORD_ONE, 1, 12, 14));
    chk(o_flags, 8'haa, "inc word flags");
    rd(5'h0e, 8'h00);
    rd(5'h0f, 8'h80);
    op(mk(micro_move_incdec_pkg::OP_INC_WORD_ONE, 0, 13, 14));
    chk(o_flags, 8'h2a, "inc odd word flags");
    rd(5'h0e, 8'h80);
    rd(5'h0f, 8'h00);
    $display("test inc word done");
  endtask

  // watchdog: a hung run counts as a mismatch
  initial begin
    repeat (5000) @(posedge i_clock);
    err_total++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    t_reset();
    t_move();
    t_cond_move();
    t_incdec_byte();
    t_cond_incdec();
    t_inc_word();
    final_report();
  end
endmodule
`default_nettype wire
